// file: ccd_pkg.sv
package ccd_pkg;

  // ****************************************************************
  // Register map of the memory-mapped control window
  // ****************************************************************
  localparam logic [7:0]  WIN_XFR_LIMIT_OFS   = 8'h52;
  localparam logic [7:0]  WIN_LOWER_LIMIT_OFS = 8'h54;
  localparam logic [7:0]  WIN_UPPER_LIMIT_OFS = 8'h56;
  // Alias location in configuration space
  localparam logic [7:0]  CFG_XFR_LIMIT_OFS   = 8'hea;

  // ****************************************************************
  // Field widths and reset values
  // ****************************************************************
  localparam int          XFR_W               = 8;
  localparam int          CLK_W               = 12;
  localparam logic [7:0]  XFR_LIMIT_RST       = 8'h08;
  localparam logic [11:0] LOWER_LIMIT_RST     = 12'h07f;
  localparam logic [11:0] UPPER_LIMIT_RST     = 12'h1c0;

  // ****************************************************************
  // Completion caching policy encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    CCD_POL_NONE  = 2'b00,
    CCD_POL_LIGHT = 2'b01,
    CCD_POL_FULL  = 2'b10,
    CCD_POL_RSVD  = 2'b11
  } ccd_policy_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [1:0]  byteEn;
    logic [15:0] wdata;
  } ccd_reg_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } ccd_reg_rsp_t;

  typedef struct packed {
    logic        cycleStart;
    logic        readHit;
    logic        xferDone;
    logic        retryTerm;
  } ccd_pci_evt_t;

endpackage : ccd_pkg

// file: ccd_idle_counter.sv
module ccd_idle_counter
  import ccd_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // Control
  input  wire logic         clear,
  input  wire logic         inc,
  // Count
  output logic [W-1:0]      count
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } ccd_cnt_state_t;

  ccd_cnt_state_t state_r;
  ccd_cnt_state_t state_nxt;

  // Saturates so a long idle never wraps back under a limit
  always_comb begin
    state_nxt = state_r;
    if (clear) begin
      state_nxt.cnt = '0;
    end else if (inc && (state_r.cnt != {W{1'b1}})) begin
      state_nxt.cnt = state_r.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign count = state_r.cnt;

endmodule : ccd_idle_counter

// file: ccd_cache_timers.sv
module ccd_cache_timers
  import ccd_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         linkResetN,
  input  wire logic         global_reset_in,
  // Memory window register port
  input  wire ccd_reg_req_t winReq,
  output ccd_reg_rsp_t      winRsp,
  // Configuration space register port
  input  wire ccd_reg_req_t cfgReq,
  output ccd_reg_rsp_t      cfgRsp,
  // Completion buffer events
  input  wire ccd_pci_evt_t pciEvt,
  input  wire logic [1:0]   completion_caching_policy,
  // Cache status
  output logic              cacheValid,
  output logic              cacheDiscard
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rstSync_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end

  logic rstN;
  assign rstN = rstSync_r[1];

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [XFR_W-1:0] xferLimit;
    logic [CLK_W-1:0] lowerLimit;
    logic [CLK_W-1:0] upperLimit;
    logic             cached;
    logic             discard;
    ccd_reg_rsp_t     winRsp;
    ccd_reg_rsp_t     cfgRsp;
  } ccd_state_t;

  ccd_state_t state_r;
  ccd_state_t state_nxt;

  // ****************************************************************
  // Idle counters
  // ****************************************************************
  logic [XFR_W-1:0] startIdle;
  logic [CLK_W-1:0] clkIdle;
  logic             idleClear;

  // Counting only runs while something is cached
  assign idleClear = !state_r.cached || pciEvt.readHit;

  ccd_idle_counter #(.W(XFR_W)) startCnt (
    .clk   (ref_clk),
    .rstN  (rstN),
    .clear (idleClear),
    .inc   (pciEvt.cycleStart),
    .count (startIdle)
  );

  ccd_idle_counter #(.W(CLK_W)) clkCnt (
    .clk   (ref_clk),
    .rstN  (rstN),
    .clear (idleClear),
    .inc   (1'b1),
    .count (clkIdle)
  );

  // ****************************************************************
  // Discard decision
  // ****************************************************************
  logic missCheckOpen;
  logic missLimitHit;
  logic upperHit;
  logic keepLeftover;

  assign missCheckOpen = clkIdle >= state_r.lowerLimit;
  assign missLimitHit  = missCheckOpen && (startIdle >= state_r.xferLimit);
  assign upperHit      = clkIdle >= state_r.upperLimit;

  always_comb begin
    unique case (ccd_policy_t'(completion_caching_policy))
      CCD_POL_LIGHT: keepLeftover = pciEvt.retryTerm;
      CCD_POL_FULL:  keepLeftover = 1'b1;
      CCD_POL_NONE:  keepLeftover = 1'b0;
      CCD_POL_RSVD:  keepLeftover = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_nxt         = state_r;
    state_nxt.discard = 1'b0;
    state_nxt.winRsp  = '0;
    state_nxt.cfgRsp  = '0;

    // Cache lifetime; a new load beats an expiry in the same cycle
    if (pciEvt.xferDone) begin
      state_nxt.cached  = keepLeftover;
      state_nxt.discard = !keepLeftover;
    end else if (state_r.cached && !pciEvt.readHit && (upperHit || missLimitHit)) begin
      state_nxt.cached  = 1'b0;
      state_nxt.discard = 1'b1;
    end

    // Memory window writes; upper bits are never stored
    if (winReq.wr) begin
      unique case (winReq.addr)
        WIN_XFR_LIMIT_OFS: begin
          if (winReq.byteEn[0]) begin
            state_nxt.xferLimit = winReq.wdata[7:0];
          end
        end
        WIN_LOWER_LIMIT_OFS: begin
          if (winReq.byteEn[0]) begin
            state_nxt.lowerLimit[7:0] = winReq.wdata[7:0];
          end
          if (winReq.byteEn[1]) begin
            state_nxt.lowerLimit[11:8] = winReq.wdata[11:8];
          end
        end
        WIN_UPPER_LIMIT_OFS: begin
          if (winReq.byteEn[0]) begin
            state_nxt.upperLimit[7:0] = winReq.wdata[7:0];
          end
          if (winReq.byteEn[1]) begin
            state_nxt.upperLimit[11:8] = winReq.wdata[11:8];
          end
        end
        default: begin
        end
      endcase
    end

    // Config alias shares storage; it wins over a window write on a collision
    if (cfgReq.wr && (cfgReq.addr == CFG_XFR_LIMIT_OFS) && cfgReq.byteEn[0]) begin
      state_nxt.xferLimit = cfgReq.wdata[7:0];
    end

    // Reads answer one cycle later; unmapped reads return zero
    if (winReq.rd) begin
      state_nxt.winRsp.ack = 1'b1;
      unique case (winReq.addr)
        WIN_XFR_LIMIT_OFS:   state_nxt.winRsp.rdata = {8'h00, state_r.xferLimit};
        WIN_LOWER_LIMIT_OFS: state_nxt.winRsp.rdata = {4'h0, state_r.lowerLimit};
        WIN_UPPER_LIMIT_OFS: state_nxt.winRsp.rdata = {4'h0, state_r.upperLimit};
        default:             state_nxt.winRsp.rdata = 16'h0000;
      endcase
    end
    if (cfgReq.rd) begin
      state_nxt.cfgRsp.ack = 1'b1;
      if (cfgReq.addr == CFG_XFR_LIMIT_OFS) begin
        state_nxt.cfgRsp.rdata = {8'h00, state_r.xferLimit};
      end
    end

    // Link or global reset restores defaults and drops the cache
    if (!linkResetN || global_reset_in) begin
      state_nxt.xferLimit  = XFR_LIMIT_RST;
      state_nxt.lowerLimit = LOWER_LIMIT_RST;
      state_nxt.upperLimit = UPPER_LIMIT_RST;
      state_nxt.cached     = 1'b0;
      state_nxt.discard    = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      state_r            <= '0;
      state_r.xferLimit  <= XFR_LIMIT_RST;
      state_r.lowerLimit <= LOWER_LIMIT_RST;
      state_r.upperLimit <= UPPER_LIMIT_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign winRsp       = state_r.winRsp;
  assign cfgRsp       = state_r.cfgRsp;
  assign cacheValid   = state_r.cached;
  assign cacheDiscard = state_r.discard;

endmodule : ccd_cache_timers

// file: ccd_cache_timers_checker.sv
module ccd_cache_timers_checker
  import ccd_pkg::*;
(
  // Clock and resets
  input wire logic         ref_clk,
  input wire logic         nrst,
  input wire logic         linkResetN,
  input wire logic         global_reset_in,
  // Register ports
  input wire ccd_reg_req_t winReq,
  input wire ccd_reg_rsp_t winRsp,
  input wire ccd_reg_req_t cfgReq,
  input wire ccd_reg_rsp_t cfgRsp,
  // Events and status
  input wire ccd_pci_evt_t pciEvt,
  input wire logic [1:0]   completion_caching_policy,
  input wire logic         cacheValid,
  input wire logic         cacheDiscard
);
  // ****
  // Properties
  // ****
  logic run;
  logic keep;
  assign run = linkResetN && !global_reset_in;
  // Reserved policy counts as no caching
  assign keep = completion_caching_policy == CCD_POL_FULL ||
                (completion_caching_policy == CCD_POL_LIGHT && pciEvt.retryTerm);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_drop;
    ##1 (!cacheValid && cacheDiscard);
  endsequence
  property p_ack; winReq.rd |=> winRsp.ack; endproperty
  property p_x52; winReq.rd && winReq.addr == WIN_XFR_LIMIT_OFS |=> winRsp.rdata[15:8] == 8'h00; endproperty
  property p_cfg; cfgReq.rd |=> cfgRsp.ack && cfgRsp.rdata[15:8] == 8'h00; endproperty
  property p_rst; !run |=> !cacheValid && !cacheDiscard; endproperty
  property p_none; run && pciEvt.xferDone && !keep |-> s_drop; endproperty
  property p_keep; run && pciEvt.xferDone && keep |=> cacheValid && !cacheDiscard; endproperty
  property p_hit; run && cacheValid && pciEvt.readHit && !pciEvt.xferDone |=> cacheValid; endproperty
  property p_fall; $fell(cacheValid) |-> cacheDiscard || !$past(run); endproperty
  a_ack: assert property (p_ack) else $error("window read not answered");
  a_x52: assert property (p_x52) else $error("upper byte of limit not zero");
  a_cfg: assert property (p_cfg) else $error("config read bad answer");
  a_rst: assert property (p_rst) else $error("cache kept over reset");
  a_none: assert property (p_none) else $error("leftover data not dropped");
  a_keep: assert property (p_keep) else $error("leftover data not cached");
  a_hit: assert property (p_hit) else $error("dropped on a read hit");
  a_fall: assert property (p_fall) else $error("cache lost without discard");
endmodule : ccd_cache_timers_checker

bind ccd_cache_timers ccd_cache_timers_checker i_ccd_cache_timers_checker (.ref_clk, .nrst,
  .linkResetN, .global_reset_in, .winReq, .winRsp, .cfgReq, .cfgRsp, .pciEvt,
  .completion_caching_policy, .cacheValid, .cacheDiscard);

// file: ccd_pci_master_model.sv
module ccd_pci_master_model
  import ccd_pkg::*;
(
  // Clock
  input  wire logic         ref_clk,
  // Bench command
  input  wire ccd_pci_evt_t evtCmd,
  // Bus events
  output ccd_pci_evt_t      pciEvt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Bus events
  // ****
  // Retry only qualifies a transfer end, never stands alone
  always @(negedge ref_clk) begin
    pciEvt <= '{evtCmd.cycleStart, evtCmd.readHit, evtCmd.xferDone,
                evtCmd.xferDone & evtCmd.retryTerm};
  end
endmodule : ccd_pci_master_model

// file: test_ccd_cache_timers.sv
module test_ccd_cache_timers
  import ccd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Harness
  // ****
  logic         ref_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         linkResetN = 1'b1;
  logic         global_reset_in = 1'b0;
  logic [1:0]   policy = 2'b10;
  ccd_reg_req_t winReq = '0;
  ccd_reg_req_t cfgReq = '0;
  ccd_reg_rsp_t winRsp;
  ccd_reg_rsp_t cfgRsp;
  ccd_pci_evt_t evtCmd = '0;
  ccd_pci_evt_t pciEvt;
  logic         cacheValid;
  logic         cacheDiscard;
  int           errors = 0;
  int           checks = 0;

  ccd_cache_timers i_ccd_cache_timers (.ref_clk(ref_clk), .nrst(nrst), .linkResetN(linkResetN),
    .global_reset_in(global_reset_in), .winReq(winReq), .winRsp(winRsp), .cfgReq(cfgReq),
    .cfgRsp(cfgRsp), .pciEvt(pciEvt), .completion_caching_policy(policy),
    .cacheValid(cacheValid), .cacheDiscard(cacheDiscard));
  ccd_pci_master_model i_ccd_pci_master_model (.ref_clk(ref_clk), .evtCmd(evtCmd),
    .pciEvt(pciEvt));

  initial forever #50 ref_clk = ~ref_clk;

  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Read checks d, write stores it; the answer is settled at the next falling edge
  // A spare cycle at the end keeps the next call from driving the same edge
  task automatic reg_op(bit cfg, bit wr, logic [7:0] a, logic [15:0] d);
    ccd_reg_req_t r;
    ccd_reg_rsp_t s;
    r = '{wr, !wr, a, 2'b11, d};
    if (cfg)
      cfgReq <= r;
    else
      winReq <= r;
    cyc(1);
    s = cfg ? cfgRsp : winRsp;
    cfgReq <= '0;
    winReq <= '0;
    chk($sformatf("reg %h ack", a), {15'h0, !wr}, {15'h0, s.ack});
    if (!wr)
      chk($sformatf("reg %h", a), d, s.rdata);
    cyc(1);
  endtask : reg_op

  task automatic rst_pulse(bit g);
    if (g)
      global_reset_in <= 1'b1;
    else
      linkResetN <= 1'b0;
    cyc(1);
    global_reset_in <= 1'b0;
    linkResetN <= 1'b1;
    cyc(1);
  endtask : rst_pulse

  task automatic send(ccd_pci_evt_t e);
    evtCmd <= e;
    cyc(1);
    evtCmd <= '0;
  endtask : send

  // ****
  // Scenarios
  // ****
  task automatic t_defaults;
    reg_op(0, 0, WIN_XFR_LIMIT_OFS, 16'h0008);
    reg_op(0, 0, WIN_LOWER_LIMIT_OFS, 16'h007f);
    reg_op(0, 0, WIN_UPPER_LIMIT_OFS, 16'h01c0);
    reg_op(1, 0, CFG_XFR_LIMIT_OFS, 16'h0008);
  endtask : t_defaults

  task automatic t_regs;
    reg_op(0, 1, WIN_XFR_LIMIT_OFS, 16'hffff);
    reg_op(0, 0, WIN_XFR_LIMIT_OFS, 16'h00ff);
    reg_op(0, 1, WIN_LOWER_LIMIT_OFS, 16'hffff);
    reg_op(0, 0, WIN_LOWER_LIMIT_OFS, 16'h0fff);
    reg_op(1, 1, CFG_XFR_LIMIT_OFS, 16'h0003);
    reg_op(0, 0, WIN_XFR_LIMIT_OFS, 16'h0003);
    reg_op(0, 0, 8'h58, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      reg_op(0, 1, WIN_UPPER_LIMIT_OFS, 16'h0123);
      rst_pulse(k[0]);
      t_defaults();
    end
  endtask : t_regs

  task automatic t_policy;
    logic [3:0] tbl [5] = '{4'b1001, 4'b0111, 4'b0100, 4'b0000, 4'b1100};
    for (int k = 0; k < 5; k++) begin
      policy <= tbl[k][3:2];
      send('{1'b0, 1'b0, 1'b1, tbl[k][1]});
      cyc(1);
      chk("cacheDiscard", {15'h0, !tbl[k][0]}, {15'h0, cacheDiscard});
      cyc(1);
      chk("cacheValid", {15'h0, tbl[k][0]}, {15'h0, cacheValid});
      rst_pulse(1'b0);
    end
  endtask : t_policy

  // Counts falling edges from the first cached cycle to the discard pulse
  task automatic t_expire(logic [15:0] lo, logic [15:0] up, logic [15:0] xl,
                          int st, int hit, int exp);
    int n;
    reg_op(0, 1, WIN_LOWER_LIMIT_OFS, lo);
    reg_op(0, 1, WIN_UPPER_LIMIT_OFS, up);
    reg_op(0, 1, WIN_XFR_LIMIT_OFS, xl);
    policy <= 2'b10;
    send('{1'b0, 1'b0, 1'b1, 1'b0});
    n = 0;
    while (cacheValid !== 1'b1 && n < 9) begin
      cyc(1);
      n++;
    end
    chk("cacheValid", 16'h0001, {15'h0, cacheValid});
    if (n == 9) begin
      test_done();
    end
    n = 0;
    while (cacheDiscard !== 1'b1 && n < 5000) begin
      evtCmd <= '{n < st, n == hit, 1'b0, 1'b0};
      cyc(1);
      n++;
    end
    evtCmd <= '0;
    chk("discard cycle", exp[15:0], n[15:0]);
    if (n == 5000) begin
      test_done();
    end
  endtask : t_expire

  initial begin
    cyc(12);
    nrst <= 1'b1;
    cyc(4);
    t_defaults();
    t_regs();
    t_policy();
    t_expire(16'h0fff, 16'd20, 16'h00ff, 0, -1, 21);
    t_expire(16'd10, 16'd40, 16'h0003, 2, -1, 41);
    t_expire(16'd10, 16'd40, 16'h0003, 3, -1, 11);
    t_expire(16'h0fff, 16'd20, 16'h00ff, 0, 5, 28);
    test_done();
  end
endmodule : test_ccd_cache_timers
